// file: logic/eewp_consts.svh
// Constants for the EEPROM write/protect host controller
`ifndef EEWP_CONSTS_SVH
`define EEWP_CONSTS_SVH
// Clock and timing
`define EEWP_CLK_NS 5
`define EEWP_WP_NS 150
`define EEWP_WP_CYC ((`EEWP_WP_NS + `EEWP_CLK_NS - 1) / `EEWP_CLK_NS)
`define EEWP_WPH_NS 50
`define EEWP_WPH_CYC ((`EEWP_WPH_NS + `EEWP_CLK_NS - 1) / `EEWP_CLK_NS)
`define EEWP_SETUP_NS 100
`define EEWP_SETUP_CYC ((`EEWP_SETUP_NS + `EEWP_CLK_NS - 1) / `EEWP_CLK_NS)
`define EEWP_ACC_NS 150
`define EEWP_ACC_CYC ((`EEWP_ACC_NS + `EEWP_CLK_NS - 1) / `EEWP_CLK_NS)
`define EEWP_BLW_US 150
`define EEWP_BLW_CYC ((`EEWP_BLW_US * 1000) / `EEWP_CLK_NS)
`define EEWP_TWC_MS 10
`define EEWP_TWC_CYC ((`EEWP_TWC_MS * 1000000) / `EEWP_CLK_NS)
// Unlock prefix
`define EEWP_UNL_A0 17'h05555
`define EEWP_UNL_D0 8'hAA
`define EEWP_UNL_A1 17'h02AAA
`define EEWP_UNL_D1 8'h55
`define EEWP_UNL_A2 17'h05555
`define EEWP_UNL_D2 8'hA0
`define EEWP_PAGE_BYTES 8'h80
`define EEWP_POLL_BIT 7
`endif

// file: logic/eewp_pkg.sv
// Types for the EEPROM write/protect host controller
package eewp_pkg;
	typedef struct packed {
		logic [16:0] addr;
		logic [15:0] data;
		logic [1:0] lanes;
		logic write;
		logic prefix;
	} eewp_req_t;
	typedef struct packed {
		logic [16:0] address_lines;
		logic [1:0] nv_select_n;
		logic [1:0] nv_write_strobe_n;
		logic oe_n;
		logic [15:0] data_o;
		logic data_oe;
	} eewp_pins_t;
	typedef enum logic [3:0] {
		EEWP_IDLE = 4'h0,
		EEWP_SETUP = 4'h1,
		EEWP_LOW = 4'h2,
		EEWP_HIGH = 4'h3,
		EEWP_NEXT = 4'h4,
		EEWP_RD = 4'h5,
		EEWP_RDONE = 4'h6,
		EEWP_POLL = 4'h7,
		EEWP_PGAP = 4'h8
	} eewp_state_t;
endpackage : eewp_pkg

// file: logic/eewp_cnt.sv
// Down counter used for the host's pin timing
`timescale 1ns/10ps
module eewp_cnt #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic [W-1:0] value,
	// Status
	output logic done
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst)
			cnt_q <= '0;
		else if (load)
			cnt_q <= value;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	// Done must not look at load: callers build load from done
	assign done = (cnt_q == '0);
endmodule : eewp_cnt

// file: logic/eewp_host.sv
// Host controller driving the EEPROM array pins for writes, reads and polling
//
// Summary of operation
// - Write only with output enable high, strobe low.
// - Next page byte within 150 us of last; the host closes the page after 75 us without a request.
// - Page address lines stable during page write.
// - AA/5555, 55/2AAA, A0/5555 enables protection.
// - Protected writes need the three-byte prefix.
// - Six-byte sequence removes protection; the host sends no such sequence and the model never clears protection.
`timescale 1ns/10ps
`include "eewp_consts.svh"
module eewp_host (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// User request
	input wire eewp_pkg::eewp_req_t req,
	input wire logic req_valid,
	input wire logic req_last,
	output logic req_ready,
	// User answer
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic prog_done,
	output logic prog_timeout,
	// Device pins
	output eewp_pkg::eewp_pins_t pins,
	input wire logic [15:0] nv_data_bus_i
);
	import eewp_pkg::*;

	// ------------------------------------------------------------
	// State and captured request
	// ------------------------------------------------------------
	eewp_state_t state_q;
	eewp_req_t cur_q;
	logic [2:0] pre_q;
	logic last_q;
	logic [7:0] nbytes_q;
	logic [15:0] sync1_q;
	logic [15:0] sync2_q;
	logic [31:0] wait_q;
	logic cnt_load;
	logic [7:0] cnt_val;
	logic cnt_done;
	logic acc_done;
	logic [16:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] poll_exp;

	eewp_cnt #(.W(8)) u_cnt (
		.clk(clk),
		.rst(rst),
		.load(cnt_load),
		.value(cnt_val),
		.done(cnt_done)
	);

	// Pin data passes two flops before any logic reads it
	always_ff @(posedge clk) begin
		sync1_q <= nv_data_bus_i;
		sync2_q <= sync1_q;
	end

	// ------------------------------------------------------------
	// Prefix sequencing: unlock bytes precede the payload
	// ------------------------------------------------------------
	always_comb begin
		// Protection removal bytes leave here as plain writes
		wr_addr = cur_q.addr;
		wr_data = cur_q.data;
		unique case (pre_q)
			3'd1: begin
				wr_addr = `EEWP_UNL_A0;
				wr_data = {2{`EEWP_UNL_D0}};
			end
			3'd2: begin
				wr_addr = `EEWP_UNL_A1;
				wr_data = {2{`EEWP_UNL_D1}};
			end
			3'd3: begin
				wr_addr = `EEWP_UNL_A2;
				wr_data = {2{`EEWP_UNL_D2}};
			end
			default: ;
		endcase
	end

	assign poll_exp = cur_q.data;
	assign req_ready = (state_q == EEWP_IDLE) || (state_q == EEWP_NEXT);

	// ------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------
	always_comb begin
		cnt_load = 1'b0;
		cnt_val = 8'h00;
		unique case (state_q)
			EEWP_IDLE, EEWP_NEXT: begin
				cnt_load = req_valid;
				cnt_val = 8'(`EEWP_SETUP_CYC);
			end
			EEWP_SETUP: begin
				cnt_load = cnt_done;
				cnt_val = 8'(`EEWP_WP_CYC);
			end
			EEWP_LOW: begin
				cnt_load = cnt_done;
				cnt_val = 8'(`EEWP_WPH_CYC);
			end
			EEWP_HIGH: begin
				// Next unlock byte and the poll gap both start from a full setup
				cnt_load = cnt_done;
				cnt_val = 8'(`EEWP_SETUP_CYC);
			end
			EEWP_RD, EEWP_POLL: begin
				cnt_load = 1'b0;
			end
			EEWP_PGAP: begin
				cnt_load = cnt_done;
				cnt_val = 8'(`EEWP_ACC_CYC);
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= EEWP_IDLE;
			cur_q <= '0;
			pre_q <= 3'd0;
			last_q <= 1'b0;
			nbytes_q <= 8'h00;
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
			prog_done <= 1'b0;
			prog_timeout <= 1'b0;
			wait_q <= 32'h0;
		end else begin
			rd_valid <= 1'b0;
			prog_done <= 1'b0;
			prog_timeout <= 1'b0;
			unique case (state_q)
				EEWP_IDLE, EEWP_NEXT: begin
					if (req_valid) begin
						cur_q <= req;
						last_q <= req_last;
						// prefix only when asked, once per page
						pre_q <= (req.write && req.prefix && state_q == EEWP_IDLE) ? 3'd1 : 3'd0;
						state_q <= req.write ? EEWP_SETUP : EEWP_RD;
						if (req.write)
							nbytes_q <= (state_q == EEWP_IDLE) ? 8'h01 : nbytes_q + 8'h01;
						wait_q <= 32'h0;
					end else if (state_q == EEWP_NEXT) begin
						// a stalled page gets programmed by the device, so poll
						wait_q <= wait_q + 32'h1;
						if (wait_q >= 32'(`EEWP_BLW_CYC / 2)) begin
							state_q <= EEWP_PGAP;
							wait_q <= 32'h0;
						end
					end
				end
				EEWP_SETUP: if (cnt_done) state_q <= EEWP_LOW;
				EEWP_LOW: if (cnt_done) state_q <= EEWP_HIGH;
				EEWP_HIGH: if (cnt_done) begin
					if (pre_q != 3'd0 && pre_q != 3'd4) begin
						pre_q <= pre_q + 3'd1;
						state_q <= EEWP_SETUP;
					end else if (last_q || nbytes_q == `EEWP_PAGE_BYTES) begin
						state_q <= EEWP_PGAP;
						wait_q <= 32'h0;
					end else
						state_q <= EEWP_NEXT;
				end
				EEWP_RD: state_q <= EEWP_RDONE;
				EEWP_RDONE: if (acc_done) begin
					rd_data <= sync2_q;
					rd_valid <= 1'b1;
					state_q <= EEWP_IDLE;
				end
				EEWP_PGAP: begin
					wait_q <= wait_q + 32'h1;
					if (cnt_done) state_q <= EEWP_POLL;
				end
				EEWP_POLL: begin
					wait_q <= wait_q + 32'h1;
					// each lane enabled in cur_q.lanes must show true polling bits
					// Compare only once the read pins have settled through the flops
					if (cnt_done
						&& (!cur_q.lanes[0] || sync2_q[`EEWP_POLL_BIT] == poll_exp[`EEWP_POLL_BIT])
						&& (!cur_q.lanes[1] || sync2_q[8 + `EEWP_POLL_BIT]
						== poll_exp[8 + `EEWP_POLL_BIT])) begin
						prog_done <= 1'b1;
						state_q <= EEWP_IDLE;
					end else if (wait_q >= 32'(`EEWP_TWC_CYC)) begin
						prog_timeout <= 1'b1;
						state_q <= EEWP_IDLE;
					end
				end
				default: state_q <= EEWP_IDLE;
			endcase
		end
	end

	// Read waits the access time once pins settle
	logic rd_arm;
	assign rd_arm = (state_q == EEWP_RD);
	eewp_cnt #(.W(8)) u_acc (
		.clk(clk),
		.rst(rst),
		.load(rd_arm),
		.value(8'(`EEWP_ACC_CYC + 2)),
		.done(acc_done)
	);

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pins.address_lines <= 17'h00000;
			pins.nv_select_n <= 2'b11;
			pins.nv_write_strobe_n <= 2'b11;
			pins.oe_n <= 1'b1;
			pins.data_o <= 16'h0000;
			pins.data_oe <= 1'b0;
		end else begin
			pins.nv_write_strobe_n <= 2'b11;
			pins.data_oe <= 1'b0;
			pins.oe_n <= 1'b1;
			pins.nv_select_n <= 2'b11;
			unique case (state_q)
				EEWP_SETUP, EEWP_LOW, EEWP_HIGH: begin
					// page lines held; OE stays high while writing
					pins.address_lines <= wr_addr;
					pins.data_o <= wr_data;
					pins.data_oe <= 1'b1;
					pins.nv_select_n <= ~cur_q.lanes;
					if (state_q == EEWP_LOW)
						pins.nv_write_strobe_n <= ~cur_q.lanes;
				end
				EEWP_RD, EEWP_RDONE, EEWP_POLL: begin
					// read with strobe high, floats otherwise
					pins.address_lines <= cur_q.addr;
					pins.nv_select_n <= ~cur_q.lanes;
					pins.oe_n <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_oe_write: assert property (@(posedge clk) disable iff (rst)
		(pins.nv_write_strobe_n != 2'b11) |-> pins.oe_n) else $error("strobe with oe low");
	chk_inhibit_pin: assert property (@(posedge clk) disable iff (rst)
		!pins.oe_n |-> !pins.data_oe) else $error("driving data during read");
	chk_pulse_width: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.nv_write_strobe_n[0]) |=> !pins.nv_write_strobe_n[0] [*8])
		else $error("strobe pulse too short");
	chk_addr_stable: assert property (@(posedge clk) disable iff (rst)
		(state_q == EEWP_LOW) |=> $stable(pins.address_lines) || state_q != EEWP_HIGH)
		else $error("address moved in write");
	chk_prefix_start: assert property (@(posedge clk) disable iff (rst)
		(state_q == EEWP_LOW && pre_q == 3'd1) |-> pins.address_lines == `EEWP_UNL_A0)
		else $error("bad unlock address");
	chk_page_count: assert property (@(posedge clk) disable iff (rst)
		nbytes_q <= `EEWP_PAGE_BYTES) else $error("page overrun");
	chk_read_float: assert property (@(posedge clk) disable iff (rst)
		(state_q == EEWP_IDLE) |=> pins.oe_n && pins.nv_select_n == 2'b11)
		else $error("pins not idle");
	chk_poll_bound: assert property (@(posedge clk) disable iff (rst)
		(state_q == EEWP_POLL) |-> wait_q <= 32'(`EEWP_TWC_CYC) + 32'd300)
		else $error("poll overran");
	cov_write: cover property (@(posedge clk) state_q == EEWP_HIGH ##1 state_q == EEWP_NEXT);
	cov_read: cover property (@(posedge clk) rd_valid);
	cov_poll: cover property (@(posedge clk) prog_done);
endmodule : eewp_host

// file: dv/eewp_nv_model.sv
// Behavioural EEPROM array seen through the host controller pins
`timescale 1ns/10ps
`include "eewp_consts.svh"
module eewp_nv_model #(
	parameter int LOAD_NS = 150000,
	parameter int PROG_NS = 6000000
) (
	// Pins from the host
	input wire eewp_pkg::eewp_pins_t pins,
	// Data pins back to the host
	output wire logic [15:0] data
);
	import eewp_pkg::*;
	logic [16:0] ua [3] = '{`EEWP_UNL_A0, `EEWP_UNL_A1, `EEWP_UNL_A2};
	logic [7:0] ud [3] = '{`EEWP_UNL_D0, `EEWP_UNL_D1, `EEWP_UNL_D2};
	// ----------
	// Byte lanes
	// ----------
	for (genvar l = 0; l < 2; l++) begin : g_lane
		logic [7:0] mem [int];
		logic [7:0] pg_d [$];
		logic [16:0] pg_a [$];
		logic [16:0] a_q, last_a;
		logic [7:0] d, last_d;
		logic [7:0] out_q = 8'h00;
		logic busy = 1'b0;
		// Set from byte acceptance until programming ends, so polling inverts at once
		logic loading = 1'b0;
		// Never cleared by the host's reset, as across a power cycle
		logic prot = 1'b0;
		int step = 0;
		time t_fall, t_ld;
		wire act = ~pins.nv_select_n[l] & ~pins.nv_write_strobe_n[l] & pins.oe_n;
		assign data[l*8 +: 8] = out_q;
		always @(negedge pins.nv_write_strobe_n[l]) t_ld = $time;
		always @(posedge act) begin
			t_fall = $time;
			a_q = pins.address_lines;
		end
		always @(negedge act) begin
			d = pins.data_o[l*8 +: 8];
			// Bytes that arrive while programming are lost, as on the real array
			if ($time - t_fall >= 8 && !busy) begin
				if (step < 3 && a_q == ua[step] && d == ud[step]) step++;
				else begin
					pg_a.push_back(a_q);
					pg_d.push_back(d);
				end
				last_a = a_q;
				last_d = d;
				loading = 1'b1;
				fork
					begin
						#(LOAD_NS);
						if ($time - t_ld >= LOAD_NS && !busy) begin
							busy = 1'b1;
							#(PROG_NS);
							if (!prot || step == 3) foreach (pg_a[i]) mem[pg_a[i]] = pg_d[i];
							prot = prot | (step == 3);
							pg_a.delete();
							pg_d.delete();
							step = 0;
							loading = 1'b0;
							busy = 1'b0;
						end
					end
				join_none
			end
		end
		// Released lanes show a changing value so a stale byte never passes
		always @(pins or busy or loading) begin
			if (!pins.nv_select_n[l] && !pins.oe_n && pins.nv_write_strobe_n[l]) begin
				if ((busy || loading) && pins.address_lines == last_a)
					out_q = {~last_d[7], last_d[6:0]};
				else out_q = mem.exists(pins.address_lines) ? mem[pins.address_lines] : 8'hFF;
			end else out_q = ~out_q;
		end
	end
endmodule : eewp_nv_model

// file: dv/tb.sv
// Self-checking bench: host controller against the EEPROM array model
`timescale 1ns/10ps
module tb;
	import eewp_pkg::*;
	localparam int LOAD_NS = 2000;
	localparam int PROG_NS = 20000;
	localparam int PROG_CYC = (LOAD_NS + PROG_NS) / 5;
	typedef struct {logic [16:0] a; logic [15:0] d; int cnt;} eewp_row_t;
	eewp_row_t rows [5] = '{'{17'h00010, 16'h1234, 1}, '{17'h1FFFF, 16'hFFFF, 1},
		'{17'h00000, 16'h0000, 1}, '{17'h00100, 16'h8001, 4}, '{17'h00200, 16'h0C00, 128}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	eewp_req_t req = '0;
	logic req_valid = 1'b0;
	logic req_last = 1'b0;
	logic req_ready, rd_valid, prog_done, prog_timeout;
	logic [15:0] rd_data, bus;
	eewp_pins_t pins;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	eewp_host eewp_host_i (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
		.req_last(req_last), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.prog_done(prog_done), .prog_timeout(prog_timeout), .pins(pins), .nv_data_bus_i(bus));
	eewp_nv_model #(.LOAD_NS(LOAD_NS), .PROG_NS(PROG_NS)) eewp_nv_model_i (.pins(pins),
		.data(bus));
	// -------
	// Helpers
	// -------
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	// An idle edge first, so valid never falls and rises in one step
	task automatic send(input logic [16:0] a, input logic [15:0] d, input logic w, p, last);
		int i;
		@(posedge clk) #1;
		req = '{addr: a, data: d, lanes: 2'b11, write: w, prefix: p};
		req_last = last;
		req_valid = 1'b1;
		for (i = 0; i < 4000 && req_ready !== 1'b1; i++) @(posedge clk) #1;
		@(posedge clk) #1;
		req_valid = 1'b0;
		check(i < 4000, "request refused");
	endtask : send
	task automatic wr_page(input logic [16:0] a, input logic [15:0] d, input int cnt, p);
		int n;
		for (int k = 0; k < cnt; k++) send(a + 17'(k), d + 16'(k), 1'b1, p[0], k == cnt - 1);
		for (n = 0; n < 3 * PROG_CYC && prog_done !== 1'b1; n++) @(posedge clk) #1;
		check(prog_done === 1'b1 && prog_timeout === 1'b0 && n >= PROG_CYC, "no completion");
	endtask : wr_page
	task automatic rd_chk(input logic [16:0] a, input logic [15:0] exp);
		int n;
		send(a, 16'h0000, 1'b0, 1'b0, 1'b1);
		for (n = 0; n < 200 && rd_valid !== 1'b1; n++) @(posedge clk) #1;
		check(rd_valid === 1'b1 && rd_data === exp, "read data mismatch");
	endtask : rd_chk
	// Writes only with output enable high, and no contention on the data pins
	// Sampled at the falling edge, where the registered pins have settled
	always @(negedge clk) begin
		cyc++;
		if (!rst && pins.oe_n !== 1'b1
			&& (pins.nv_write_strobe_n !== 2'b11 || pins.data_oe !== 1'b0)) begin
			n_errors++;
			$display("[ERR] %0t strobe or data driven while reading", $time);
		end
		if (cyc == 90000) begin
			n_errors++;
			$display("[ERR] %0t run timed out", $time);
			end_of_test();
		end
	end
	// --------
	// Sequence
	// --------
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		check(pins.nv_select_n === 2'b11 && pins.oe_n === 1'b1 && pins.data_oe === 1'b0, "idle pins");
		foreach (rows[r]) begin
			wr_page(rows[r].a, rows[r].d, rows[r].cnt, 0);
			for (int k = 0; k < rows[r].cnt; k++) rd_chk(rows[r].a + 17'(k), rows[r].d + 16'(k));
			$display("row %0d done", r);
		end
		wr_page(17'h00300, 16'h1111, 1, 1);
		rd_chk(17'h00300, 16'h1111);
		wr_page(17'h00300, 16'h2222, 1, 0);
		rd_chk(17'h00300, 16'h1111);
		wr_page(17'h00300, 16'h3333, 1, 1);
		rd_chk(17'h00300, 16'h3333);
		$display("protection done");
		@(posedge clk) #1 rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		check(pins.nv_write_strobe_n === 2'b11 && pins.data_oe === 1'b0, "idle pins after reset");
		wr_page(17'h00300, 16'h4444, 1, 0);
		rd_chk(17'h00300, 16'h3333);
		$display("second reset done");
		end_of_test();
	end
endmodule : tb
